// *** hw/asr_top.sv ***
// receive status flags, data buffer and bit rate generator
//
// Strobed register access was left to the implementer.
`timescale 1ns/10ps
module asr_top
   import asr_pkg::*;
(
   input wire logic clk_i,
   input wire logic srst_i,
   input wire logic [ADDR_W-1:0] addr_i,
   input wire logic [DATA_W-1:0] wdata_i,
   input wire logic wr_i,
   input wire logic rd_i,
   output logic [DATA_W-1:0] rdata_o,
   input wire asr_rx_evt_t rx_evt_i,
   input wire logic serial_receive_pin_i,
   output asr_rate_t rate_o,
   output logic [DATA_W-1:0] tx_data_o,
   output logic tx_load_o,
   output logic nine_bit_mode_o,
   output logic error_irq_o,
   output logic irq_o
);
   logic [DATA_W-1:0] rx_data_buffer_q;
   logic rx_ninth_bit_q;
   logic receive_full_flag_q;
   logic noise_detect_flag_q;
   logic framing_error_flag_q;
   logic parity_error_flag_q;
   logic break_detect_flag_q;
   logic rx_in_progress_flag_q;
   logic break_armed_q;
   logic noise_irq_enable_q;
   logic framing_irq_enable_q;
   logic parity_irq_enable_q;
   logic nine_mode_q;
   logic [1:0] prescaler_field_q;
   logic [2:0] rate_divisor_field_q;
   logic [IRQ_W-1:0] irq_stat_q;
   logic [IRQ_W-1:0] irq_mask_q;
   logic [3:0] clr_arm_q;
   logic brk_arm_q;
   logic pin_meta_q;
   logic pin_sync_q;
   logic [DATA_W-1:0] rdata_q;
   logic [DATA_W-1:0] tx_data_q;
   logic tx_load_q;

   logic wr_c3, wr_br, wr_ist, wr_msk, wr_dat;
   logic rd_ps, rd_ss, rd_dat;
   logic brk_take, full_set, frame_set;
   logic clr_full, clr_noise, clr_frame, clr_parity, clr_brk;
   logic [DATA_W-1:0] primary_status, secondary_status, third_control_reg;
   logic [DATA_W-1:0] bit_rate_select;
   logic [IRQ_W-1:0] ev_vec;

   assign wr_c3 = wr_i && (addr_i == ADR_CONTROL3);
   assign wr_br = wr_i && (addr_i == ADR_BIT_RATE);
   assign wr_ist = wr_i && (addr_i == ADR_IRQ_STATUS);
   assign wr_msk = wr_i && (addr_i == ADR_IRQ_MASK);
   assign wr_dat = wr_i && (addr_i == ADR_DATA);
   assign rd_ps = rd_i && (addr_i == ADR_PRIMARY);
   assign rd_ss = rd_i && (addr_i == ADR_SECONDARY);
   assign rd_dat = rd_i && (addr_i == ADR_DATA);

   // pin passes two flops before use
   always_ff @(posedge clk_i) begin
      if (srst_i) begin
         pin_meta_q <= 1'b0;
         pin_sync_q <= 1'b0;
      end else begin
         pin_meta_q <= serial_receive_pin_i;
         pin_sync_q <= pin_meta_q;
      end
   end

   // break only counts when the line has been high since the last one
   assign brk_take = rx_evt_i.brk && break_armed_q;
   assign full_set = rx_evt_i.char_done || rx_evt_i.brk;
   assign frame_set = rx_evt_i.framing || rx_evt_i.brk;

   // clear sequence: status read arms the flags seen set, data read clears
   assign clr_full = rd_dat && clr_arm_q[EV_FULL];
   assign clr_noise = rd_dat && clr_arm_q[EV_NOISE];
   assign clr_frame = rd_dat && clr_arm_q[EV_FRAME];
   assign clr_parity = rd_dat && clr_arm_q[EV_PARITY];
   assign clr_brk = rd_dat && brk_arm_q;

   always_ff @(posedge clk_i) begin
      if (srst_i) begin
         clr_arm_q <= '0;
         brk_arm_q <= 1'b0;
      end else begin
         if (rd_ps) begin
            clr_arm_q[EV_FULL] <= receive_full_flag_q;
            clr_arm_q[EV_NOISE] <= noise_detect_flag_q;
            clr_arm_q[EV_FRAME] <= framing_error_flag_q;
            clr_arm_q[EV_PARITY] <= parity_error_flag_q;
         end else if (rd_dat) begin
            clr_arm_q <= '0;
         end
         if (rd_ss) begin
            brk_arm_q <= break_detect_flag_q;
         end else if (rd_dat) begin
            brk_arm_q <= 1'b0;
         end
      end
   end

   // error flags and receive full flag: a set in the clearing cycle wins
   always_ff @(posedge clk_i) begin
      if (srst_i) begin
         noise_detect_flag_q <= 1'b0;
         framing_error_flag_q <= 1'b0;
         parity_error_flag_q <= 1'b0;
         receive_full_flag_q <= 1'b0;
      end else begin
         if (rx_evt_i.noise) begin
            noise_detect_flag_q <= 1'b1;
         end else if (clr_noise) begin
            noise_detect_flag_q <= 1'b0;
         end
         if (frame_set) begin
            framing_error_flag_q <= 1'b1;
         end else if (clr_frame) begin
            framing_error_flag_q <= 1'b0;
         end
         if (rx_evt_i.parity) begin
            parity_error_flag_q <= 1'b1;
         end else if (clr_parity) begin
            parity_error_flag_q <= 1'b0;
         end
         if (full_set) begin
            receive_full_flag_q <= 1'b1;
         end else if (clr_full) begin
            receive_full_flag_q <= 1'b0;
         end
      end
   end

   // break flag and its rearm latch
   always_ff @(posedge clk_i) begin
      if (srst_i) begin
         break_detect_flag_q <= 1'b0;
         break_armed_q <= 1'b1;
      end else begin
         if (brk_take) begin
            break_detect_flag_q <= 1'b1;
         end else if (clr_brk) begin
            break_detect_flag_q <= 1'b0;
         end
         if (brk_take) begin
            break_armed_q <= 1'b0;
         end else if (pin_sync_q && !break_detect_flag_q) begin
            break_armed_q <= 1'b1;
         end
      end
   end

   // reception in progress; a completed character also ends it
   always_ff @(posedge clk_i) begin
      if (srst_i) begin
         rx_in_progress_flag_q <= 1'b0;
      end else if (rx_evt_i.start_zero) begin
         rx_in_progress_flag_q <= 1'b1;
      end else if (rx_evt_i.false_start || rx_evt_i.idle
                   || rx_evt_i.char_done) begin
         rx_in_progress_flag_q <= 1'b0;
      end
   end

   // data buffer has no reset on purpose
   always_ff @(posedge clk_i) begin
      if (rx_evt_i.brk) begin
         rx_data_buffer_q <= '0;
         rx_ninth_bit_q <= 1'b0;
      end else if (rx_evt_i.char_done) begin
         rx_data_buffer_q <= rx_evt_i.data[DATA_W-1:0];
         rx_ninth_bit_q <= nine_mode_q ? rx_evt_i.data[DATA_W]
                                      : rx_evt_i.data[DATA_W-1];
      end
   end

   // transmit byte handed to the transmitter, not reset either
   always_ff @(posedge clk_i) begin
      if (wr_dat) begin
         tx_data_q <= wdata_i;
      end
   end

   always_ff @(posedge clk_i) begin
      if (srst_i) begin
         tx_load_q <= 1'b0;
      end else begin
         tx_load_q <= wr_dat;
      end
   end

   // control and rate registers
   always_ff @(posedge clk_i) begin
      if (srst_i) begin
         noise_irq_enable_q <= 1'b0;
         framing_irq_enable_q <= 1'b0;
         parity_irq_enable_q <= 1'b0;
         nine_mode_q <= 1'b0;
         prescaler_field_q <= PRE_RESET;
         rate_divisor_field_q <= RATE_RESET;
         irq_mask_q <= '0;
      end else begin
         if (wr_c3) begin
            nine_mode_q <= wdata_i[C3_NINE_MODE];
            noise_irq_enable_q <= wdata_i[C3_NOISE_EN];
            framing_irq_enable_q <= wdata_i[C3_FRAME_EN];
            parity_irq_enable_q <= wdata_i[C3_PARITY_EN];
         end
         if (wr_br) begin
            prescaler_field_q <= wdata_i[BR_PRE_LO +: 2];
            rate_divisor_field_q <= wdata_i[BR_RATE_LO +: 3];
         end
         if (wr_msk) begin
            irq_mask_q <= wdata_i[IRQ_W-1:0];
         end
      end
   end

   // sticky events, write one to clear, set wins; break has no bit of its own but sets full and framing
   assign ev_vec[EV_FULL] = full_set;
   assign ev_vec[EV_NOISE] = rx_evt_i.noise;
   assign ev_vec[EV_FRAME] = frame_set;
   assign ev_vec[EV_PARITY] = rx_evt_i.parity;

   generate
      for (genvar i = 0; i < IRQ_W; i++) begin : g_ev
         always_ff @(posedge clk_i) begin
            if (srst_i) begin
               irq_stat_q[i] <= 1'b0;
            end else if (ev_vec[i]) begin
               irq_stat_q[i] <= 1'b1;
            end else if (wr_ist && wdata_i[i]) begin
               irq_stat_q[i] <= 1'b0;
            end
         end
      end
   endgenerate

   assign irq_o = |(irq_stat_q & irq_mask_q);
   assign error_irq_o = (noise_detect_flag_q && noise_irq_enable_q)
                     || (framing_error_flag_q && framing_irq_enable_q)
                     || (parity_error_flag_q && parity_irq_enable_q);

   // register views
   always_comb begin
      primary_status = '0;
      primary_status[PS_FULL] = receive_full_flag_q;
      primary_status[PS_NOISE] = noise_detect_flag_q;
      primary_status[PS_FRAME] = framing_error_flag_q;
      primary_status[PS_PARITY] = parity_error_flag_q;
      secondary_status = '0;
      secondary_status[SS_BREAK] = break_detect_flag_q;
      secondary_status[SS_PROGRESS] = rx_in_progress_flag_q;
      third_control_reg = '0;
      third_control_reg[C3_NINTH] = rx_ninth_bit_q;
      third_control_reg[C3_NINE_MODE] = nine_mode_q;
      third_control_reg[C3_NOISE_EN] = noise_irq_enable_q;
      third_control_reg[C3_FRAME_EN] = framing_irq_enable_q;
      third_control_reg[C3_PARITY_EN] = parity_irq_enable_q;
      bit_rate_select = '0;
      bit_rate_select[BR_PRE_LO +: 2] = prescaler_field_q;
      bit_rate_select[BR_RATE_LO +: 3] = rate_divisor_field_q;
   end

   // read data valid the cycle after the strobe only
   always_ff @(posedge clk_i) begin
      if (srst_i) begin
         rdata_q <= '0;
      end else if (rd_i) begin
         case (addr_i)
            ADR_CONTROL3: rdata_q <= third_control_reg;
            ADR_PRIMARY: rdata_q <= primary_status;
            ADR_SECONDARY: rdata_q <= secondary_status;
            ADR_DATA: rdata_q <= rx_data_buffer_q;
            ADR_BIT_RATE: rdata_q <= bit_rate_select;
            ADR_IRQ_STATUS: rdata_q <= {{(DATA_W-IRQ_W){1'b0}}, irq_stat_q};
            ADR_IRQ_MASK: rdata_q <= {{(DATA_W-IRQ_W){1'b0}}, irq_mask_q};
            default: rdata_q <= '0;
         endcase
      end else begin
         rdata_q <= '0;
      end
   end

   // bit rate: prescaler, then power-of-two stage, then fixed 64
   logic [3:0] pd_m1;
   logic [6:0] bd_m1;
   logic [3:0] pre_cnt_q;
   logic [6:0] rate_cnt_q;
   logic [1:0] slot_cnt_q;
   logic [3:0] bit_cnt_q;
   logic slot_tick_q, bit_tick_q;
   logic pre_wrap, rate_wrap, slot_wrap;

   always_comb begin
      case (prescaler_field_q)
         2'h0: pd_m1 = PD_CODE0 - 4'h1;
         2'h1: pd_m1 = PD_CODE1 - 4'h1;
         2'h2: pd_m1 = PD_CODE2 - 4'h1;
         default: pd_m1 = PD_CODE3 - 4'h1;
      endcase
   end
   assign bd_m1 = 7'((8'h01 << rate_divisor_field_q) - 8'h01);

   assign pre_wrap = (pre_cnt_q == pd_m1);
   assign rate_wrap = pre_wrap && (rate_cnt_q == bd_m1);
   assign slot_wrap = rate_wrap && (slot_cnt_q == 2'(SLOT_DIV - 1));

   // one rate serves both directions; a field change restarts the chain
   always_ff @(posedge clk_i) begin
      if (srst_i || wr_br) begin
         pre_cnt_q <= '0;
         rate_cnt_q <= '0;
         slot_cnt_q <= '0;
         bit_cnt_q <= '0;
         slot_tick_q <= 1'b0;
         bit_tick_q <= 1'b0;
      end else begin
         pre_cnt_q <= pre_wrap ? 4'h0 : pre_cnt_q + 4'h1;
         if (pre_wrap) begin
            rate_cnt_q <= (rate_cnt_q == bd_m1) ? 7'h00 : rate_cnt_q + 7'h01;
         end
         if (rate_wrap) begin
            slot_cnt_q <= slot_cnt_q + 2'h1;
         end
         if (slot_wrap) begin
            bit_cnt_q <= bit_cnt_q + 4'h1;
         end
         slot_tick_q <= slot_wrap;
         bit_tick_q <= slot_wrap && (bit_cnt_q == 4'(SLOTS_PER_BIT - 1));
      end
   end

   assign rate_o.slot_tick = slot_tick_q;
   assign rate_o.bit_tick = bit_tick_q;
   assign rdata_o = rdata_q;
   assign tx_data_o = tx_data_q;
   assign tx_load_o = tx_load_q;
   assign nine_bit_mode_o = nine_mode_q;
endmodule

// *** hw/asr_pkg.sv ***
// constants, field layouts and carrier types of the serial receive status unit
package asr_pkg;
   localparam int ADDR_W = 8;
   localparam int DATA_W = 8;

   localparam logic [7:0] ADR_CONTROL3 = 8'h15;
   localparam logic [7:0] ADR_PRIMARY = 8'h16;
   localparam logic [7:0] ADR_SECONDARY = 8'h17;
   localparam logic [7:0] ADR_DATA = 8'h18;
   localparam logic [7:0] ADR_BIT_RATE = 8'h19;
   localparam logic [7:0] ADR_IRQ_STATUS = 8'h1A;
   localparam logic [7:0] ADR_IRQ_MASK = 8'h1B;

   // primary status fields
   localparam int PS_FULL = 5;
   localparam int PS_NOISE = 2;
   localparam int PS_FRAME = 1;
   localparam int PS_PARITY = 0;
   // secondary status fields
   localparam int SS_BREAK = 1;
   localparam int SS_PROGRESS = 0;
   // third control fields
   localparam int C3_NINTH = 7;
   localparam int C3_NINE_MODE = 6;
   localparam int C3_NOISE_EN = 2;
   localparam int C3_FRAME_EN = 1;
   localparam int C3_PARITY_EN = 0;
   // bit rate fields
   localparam int BR_PRE_LO = 4;
   localparam int BR_RATE_LO = 0;
   // sticky event bits, also mask layout
   localparam int IRQ_W = 4;
   localparam int EV_FULL = 0;
   localparam int EV_NOISE = 1;
   localparam int EV_FRAME = 2;
   localparam int EV_PARITY = 3;

   localparam logic [1:0] PRE_RESET = 2'h0;
   localparam logic [2:0] RATE_RESET = 3'h0;
   localparam logic [3:0] PD_CODE0 = 4'h1;
   localparam logic [3:0] PD_CODE1 = 4'h3;
   localparam logic [3:0] PD_CODE2 = 4'h4;
   localparam logic [3:0] PD_CODE3 = 4'hD;
   // 64 = 4 rate-stage ticks per sample slot times 16 slots per bit
   localparam int FIXED_DIV = 64;
   localparam int SLOTS_PER_BIT = 16;
   localparam int SLOT_DIV = FIXED_DIV / SLOTS_PER_BIT;

   // events from the bit-level receive engine, same clock
   typedef struct packed {
      logic char_done;
      logic [8:0] data;
      logic noise;
      logic framing;
      logic parity;
      logic brk;
      logic start_zero;
      logic false_start;
      logic idle;
   } asr_rx_evt_t;

   typedef struct packed {
      logic slot_tick;
      logic bit_tick;
   } asr_rate_t;
endpackage

// *** verif/asr_chk.sv ***
// concurrent checks on the ports of the receive status unit
`timescale 1ns/10ps
module asr_chk
   import asr_pkg::*;
(
   input wire logic clk_i,
   input wire logic srst_i,
   input wire logic [ADDR_W-1:0] addr_i,
   input wire logic [DATA_W-1:0] wdata_i,
   input wire logic wr_i,
   input wire logic rd_i,
   input wire logic [DATA_W-1:0] rdata_o,
   input wire asr_rx_evt_t rx_evt_i,
   input wire logic serial_receive_pin_i,
   input wire asr_rate_t rate_o,
   input wire logic [DATA_W-1:0] tx_data_o,
   input wire logic tx_load_o,
   input wire logic nine_bit_mode_o,
   input wire logic error_irq_o,
   input wire logic irq_o
);
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (srst_i);
   logic [2:0] en_q;
   logic [IRQ_W-1:0] msk_q;
   logic fresh_q;
   int gap_q;
   int div_q;
   logic quiet;
   // no bus or error traffic that could move the request lines
   assign quiet = !wr_i && !rd_i && !rx_evt_i.char_done &&
      !rx_evt_i.noise && !rx_evt_i.framing && !rx_evt_i.parity;
   function automatic int pd_of(input logic [1:0] c);
      case (c)
         2'h0: return 1;
         2'h1: return 3;
         2'h2: return 4;
         default: return 13;
      endcase
   endfunction
   always_ff @(posedge clk_i) begin
      if (srst_i) begin
         en_q <= 3'h0;
      end else if (wr_i && addr_i == ADR_CONTROL3) begin
         en_q <= wdata_i[2:0];
      end
   end
   always_ff @(posedge clk_i) begin
      if (srst_i) begin
         msk_q <= '0;
      end else if (wr_i && addr_i == ADR_IRQ_MASK) begin
         msk_q <= wdata_i[IRQ_W-1:0];
      end
   end
   always_ff @(posedge clk_i) begin
      if (srst_i) begin
         div_q <= 4;
      end else if (wr_i && addr_i == ADR_BIT_RATE) begin
         div_q <= 4 * pd_of(wdata_i[5:4]) * (1 << wdata_i[2:0]);
      end
   end
   // first tick after a restart is spaced from a tick of the old chain, so it is not judged
   always_ff @(posedge clk_i) begin
      if (srst_i || (wr_i && addr_i == ADR_BIT_RATE)) begin
         fresh_q <= 1'b1;
      end else if (rate_o.slot_tick) begin
         fresh_q <= 1'b0;
      end
   end
   always_ff @(posedge clk_i) begin
      if (rate_o.slot_tick) begin
         gap_q <= 0;
      end else begin
         gap_q <= gap_q + 1;
      end
   end
   sequence s_data_wr;
      wr_i && addr_i == ADR_DATA;
   endsequence
   sequence s_loaded;
      tx_load_o && tx_data_o == $past(wdata_i);
   endsequence
   AST_TX_LOAD: assert property (s_data_wr |=> s_loaded)
      else $error("transmit byte not loaded after data write");
   AST_NOISE_IRQ: assert property (rx_evt_i.noise && en_q[C3_NOISE_EN]
      && !wr_i |=> error_irq_o) else $error("noise request missing");
   AST_FRAME_IRQ: assert property (rx_evt_i.framing && en_q[C3_FRAME_EN]
      && !wr_i |=> error_irq_o) else $error("framing request missing");
   AST_PARITY_IRQ: assert property (rx_evt_i.parity
      && en_q[C3_PARITY_EN] && !wr_i |=> error_irq_o)
      else $error("parity request missing");
   // break also raises full and framing, so only judge with those masked
   AST_BRK_QUIET: assert property (rx_evt_i.brk && quiet
      && !en_q[C3_FRAME_EN] && !msk_q[EV_FULL] && !msk_q[EV_FRAME]
      |=> $stable(irq_o) && $stable(error_irq_o))
      else $error("break moved the interrupt");
   AST_PROG_QUIET: assert property (rx_evt_i.start_zero && quiet
      |=> $stable(irq_o) && $stable(error_irq_o))
      else $error("progress flag moved a request");
   AST_SLOT_GAP: assert property (rate_o.slot_tick && !fresh_q
      |-> gap_q == div_q - 1) else $error("slot tick spacing wrong");
   AST_RST_CLR: assert property (@(posedge clk_i) disable iff (1'b0)
      srst_i |=> !error_irq_o && !irq_o && !tx_load_o && rdata_o == 8'h00)
      else $error("outputs not cleared by reset");
   AST_RD_IDLE: assert property (!rd_i |=> rdata_o == 8'h00)
      else $error("read data outside read answer");
endmodule
bind asr_top asr_chk asr_chk_inst (.clk_i(clk_i), .srst_i(srst_i),
   .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i),
   .rdata_o(rdata_o), .rx_evt_i(rx_evt_i),
   .serial_receive_pin_i(serial_receive_pin_i), .rate_o(rate_o),
   .tx_data_o(tx_data_o), .tx_load_o(tx_load_o),
   .nine_bit_mode_o(nine_bit_mode_o), .error_irq_o(error_irq_o),
   .irq_o(irq_o));

// *** verif/asr_remote_tx.sv ***
// far-end transmitter model: receive events and raw line level
`timescale 1ns/10ps
module asr_remote_tx
   import asr_pkg::*;
(
   input wire logic clk_i,
   output asr_rx_evt_t rx_evt_o,
   output logic line_o
);
   initial begin
      rx_evt_o = '0;
      line_o = 1'b1;
   end
   // one-cycle event, returns once the flag update has landed
   task automatic pulse(input asr_rx_evt_t e);
      @(posedge clk_i);
      rx_evt_o <= e;
      @(posedge clk_i);
      rx_evt_o <= '0;
      #1;
   endtask
   // a break holds the line low; ones must reappear before the next one
   task automatic hold_line(input logic lvl, input int n);
      @(posedge clk_i);
      line_o <= lvl;
      repeat (n) @(posedge clk_i);
   endtask
endmodule

// *** verif/asr_top_bench.sv ***
// self-checking bench for the receive status unit
`timescale 1ns/10ps
`define CHK(nm, e, g) begin cmp_count++; if ((g) !== (e)) begin \
   num_errors++; $display("CHECK FAILED %s exp %h got %h", nm, e, g); end end
module asr_top_bench;
   import asr_pkg::*;
   logic clk_i = 1'b0;
   logic srst_i = 1'b1;
   logic [7:0] addr_i = 8'h00;
   logic [7:0] wdata_i = 8'h00;
   logic wr_i = 1'b0;
   logic rd_i = 1'b0;
   logic [7:0] rdata_o;
   logic [7:0] tx_data_o;
   logic tx_load_o, nine_bit_mode_o, error_irq_o, irq_o, line;
   asr_rx_evt_t evt, e;
   asr_rate_t rate_o;
   int num_errors = 0;
   int cmp_count = 0;
   asr_remote_tx asr_remote_tx_inst (.clk_i(clk_i), .rx_evt_o(evt),
      .line_o(line));
   asr_top asr_top_inst (.clk_i(clk_i), .srst_i(srst_i), .addr_i(addr_i),
      .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
      .rx_evt_i(evt), .serial_receive_pin_i(line), .rate_o(rate_o),
      .tx_data_o(tx_data_o), .tx_load_o(tx_load_o),
      .nine_bit_mode_o(nine_bit_mode_o), .error_irq_o(error_irq_o),
      .irq_o(irq_o));
   initial begin
      forever #10 clk_i = ~clk_i;
   end
   task automatic tally_and_finish();
      $display("compares %0d mismatches %0d", cmp_count, num_errors);
      if (num_errors == 0 && cmp_count > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask
   task automatic bus_wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge clk_i);
      addr_i <= a;
      wdata_i <= d;
      wr_i <= 1'b1;
      @(posedge clk_i);
      wr_i <= 1'b0;
      #1;
   endtask
   task automatic rd_chk(input logic [7:0] a, m, ex, input string nm);
      @(posedge clk_i);
      addr_i <= a;
      rd_i <= 1'b1;
      @(posedge clk_i);
      rd_i <= 1'b0;
      #1 `CHK(nm, ex, rdata_o & m)
   endtask
   task automatic ev_char(input logic [8:0] d);
      e = '0;
      e.char_done = 1'b1;
      e.data = d;
      asr_remote_tx_inst.pulse(e);
   endtask
   task automatic t_char();
      ev_char(9'h0A5);
      bus_wr(ADR_IRQ_MASK, 8'h01);
      `CHK("irq_full", 1'b1, irq_o)
      rd_chk(ADR_PRIMARY, 8'h20, 8'h20, "full");
      rd_chk(ADR_DATA, 8'hFF, 8'hA5, "rx_byte");
      rd_chk(ADR_PRIMARY, 8'h20, 8'h00, "full_clr");
      bus_wr(ADR_DATA, 8'h3C);
      `CHK("tx_byte", 9'h13C, {tx_load_o, tx_data_o})
      bus_wr(ADR_IRQ_STATUS, 8'h01);
      `CHK("irq_w1c", 1'b0, irq_o)
      @(posedge clk_i);
      srst_i <= 1'b1;
      @(posedge clk_i);
      srst_i <= 1'b0;
      rd_chk(ADR_DATA, 8'hFF, 8'hA5, "kept");
   endtask
   task automatic t_errs();
      logic [7:0] m;
      for (int k = 0; k < 3; k++) begin
         m = 8'h01 << (2 - k);
         e = '0;
         {e.noise, e.framing, e.parity} = m[2:0];
         bus_wr(ADR_CONTROL3, ~m & 8'h07);
         asr_remote_tx_inst.pulse(e);
         `CHK("req_off", 1'b0, error_irq_o)
         bus_wr(ADR_CONTROL3, m);
         `CHK("req_on", 1'b1, error_irq_o)
         rd_chk(ADR_DATA, 8'hFF, 8'hA5, "unarmed");
         rd_chk(ADR_PRIMARY, m, m, "err_set");
         rd_chk(ADR_DATA, 8'hFF, 8'hA5, "clear");
         rd_chk(ADR_PRIMARY, m, 8'h00, "err_clr");
      end
   endtask
   task automatic t_brk();
      bus_wr(ADR_CONTROL3, 8'h40);
      `CHK("nine_out", 1'b1, nine_bit_mode_o)
      ev_char(9'h1FF);
      rd_chk(ADR_CONTROL3, 8'h80, 8'h80, "ninth_one");
      bus_wr(ADR_IRQ_STATUS, 8'h0F);
      // full and framing masked: break raises those two on its own
      bus_wr(ADR_IRQ_MASK, 8'h0A);
      asr_remote_tx_inst.hold_line(1'b0, 3);
      e = '0;
      e.brk = 1'b1;
      asr_remote_tx_inst.pulse(e);
      `CHK("brk_irq", 1'b0, irq_o)
      `CHK("brk_err", 1'b0, error_irq_o)
      rd_chk(ADR_IRQ_STATUS, 8'h0F, 8'h05, "brk_stat");
      rd_chk(ADR_PRIMARY, 8'h22, 8'h22, "brk_fe_full");
      rd_chk(ADR_CONTROL3, 8'h80, 8'h00, "ninth_zero");
      rd_chk(ADR_SECONDARY, 8'h02, 8'h02, "brk_set");
      rd_chk(ADR_DATA, 8'hFF, 8'h00, "brk_data");
      rd_chk(ADR_SECONDARY, 8'h02, 8'h00, "brk_clr");
      asr_remote_tx_inst.pulse(e);
      rd_chk(ADR_SECONDARY, 8'h02, 8'h00, "no_rearm");
      asr_remote_tx_inst.hold_line(1'b1, 4);
      asr_remote_tx_inst.hold_line(1'b0, 2);
      asr_remote_tx_inst.pulse(e);
      rd_chk(ADR_SECONDARY, 8'h02, 8'h02, "rearmed");
      asr_remote_tx_inst.hold_line(1'b1, 2);
   endtask
   task automatic t_prog();
      e = '0;
      e.start_zero = 1'b1;
      asr_remote_tx_inst.pulse(e);
      `CHK("prog_irq", 1'b0, irq_o)
      rd_chk(ADR_SECONDARY, 8'h01, 8'h01, "prog_set");
      e = '0;
      e.false_start = 1'b1;
      asr_remote_tx_inst.pulse(e);
      rd_chk(ADR_SECONDARY, 8'h01, 8'h00, "false_st");
      e = '0;
      e.start_zero = 1'b1;
      asr_remote_tx_inst.pulse(e);
      e = '0;
      e.idle = 1'b1;
      asr_remote_tx_inst.pulse(e);
      rd_chk(ADR_SECONDARY, 8'h01, 8'h00, "idle");
   endtask
   task automatic t_rate(input logic [7:0] v, input int ex);
      int n;
      bus_wr(ADR_BIT_RATE, v);
      rd_chk(ADR_BIT_RATE, 8'h37, v, "rate_reg");
      n = 0;
      while (rate_o.slot_tick !== 1'b1 && n < 20000) begin
         @(posedge clk_i);
         #1 n++;
      end
      n = 0;
      do begin
         @(posedge clk_i);
         #1 n++;
      end while (rate_o.slot_tick !== 1'b1 && n < 20000);
      `CHK("slot_gap", ex, n)
      // bit tick spans sixteen slots; the slowest setting is skipped
      if (ex < 1000) begin
         n = 0;
         while (rate_o.bit_tick !== 1'b1 && n < 20000) begin
            @(posedge clk_i);
            #1 n++;
         end
         n = 0;
         do begin
            @(posedge clk_i);
            #1 n++;
         end while (rate_o.bit_tick !== 1'b1 && n < 20000);
         `CHK("bit_gap", SLOTS_PER_BIT * ex, n)
      end
   endtask
   initial begin
      repeat (60000) @(posedge clk_i);
      num_errors++;
      tally_and_finish();
   end
   initial begin
      int pdv[4] = '{1, 3, 4, 13};
      repeat (8) @(posedge clk_i);
      srst_i <= 1'b0;
      rd_chk(ADR_PRIMARY, 8'h27, 8'h00, "ps_rst");
      rd_chk(ADR_SECONDARY, 8'h03, 8'h00, "ss_rst");
      rd_chk(ADR_BIT_RATE, 8'h37, 8'h00, "br_rst");
      rd_chk(8'h20, 8'hFF, 8'h00, "unmapped");
      t_char();
      t_errs();
      t_brk();
      t_prog();
      for (int k = 0; k < 4; k++) begin
         t_rate(8'((k << 4) | k), 4 * pdv[k] * (1 << k));
      end
      t_rate(8'h37, 4 * 13 * 128);
      tally_and_finish();
   end
endmodule
